// file: core/uhb_dev.sv
// uhb_dev: device end of the host byte port, register file, irq, clock pins
// assumes: port pins arrive asynchronously; the oscillator itself is analog
// assumes: the host holds select, address and write byte through the whole strobe
// assumes: strobes last at least five clocks, so the three-flop agreement lands inside
// assumes: the rts pin is steady for a few clocks before reset is released
`timescale 1ns/1ps
module uhb_dev (
   input wire logic clk_sys_i,                       // system clock
   input wire logic rst_i,                           // synchronous reset, high
   uhb_if.dev bus,                                   // host side
   input wire logic [uhb_pkg::SRC_W-1:0] src_evt_i,  // interrupt events, pulses
   input wire logic rts_pin_i,                       // request-to-send pin level
   output logic rts_pin_oe_n_o,                      // rts drive enable, low drives
   output logic rts_pin_o,                           // rts drive value
   input wire logic rts_req_i,                       // rts level asked for by core
   output logic gp_out_or_xtal_out_o,                // second clock pin value
   output logic gp_out_or_xtal_out_oe_n_o,           // second clock pin enable
   input wire logic osc_fb_i,                        // oscillator inverter feedback
   output logic [7:0] gp_out_o,                      // mirror of gp register
   output logic clk_mode_o                           // latched clock mode
);
   import uhb_pkg::*;

   // synchroniser triples and registers, all in one struct
   typedef struct packed {
      // raw pin samples, three flops each
      logic [2:0] cs_s;              // select samples, newest in bit 0
      logic [2:0] rd_s;              // read strobe samples
      logic [2:0] wr_s;              // write strobe samples
      logic [2:0] rts_s;             // request-to-send pin samples
      // levels once the second and third flops agree
      logic rd_q;                    // agreed read level (active low)
      logic wr_q;                    // agreed write level (active low)
      logic cs_q;                    // agreed select level (active low)
      // read return path
      logic [7:0] rdat;              // read data held on bus
      logic drv;                     // drive bus this cycle
      // host-visible registers
      logic [7:0] scratch;           // plain read/write byte
      logic [SRC_W-1:0] stat;        // sticky source status
      logic [SRC_W-1:0] smask;       // per-source mask, second level
      logic glb_en;                  // block enable, first level
      logic gp;                      // general output two level
      // clock pin configuration
      logic mode;                    // 1 = crystal
      logic rst_seen;                // first cycle after reset has passed
      // interrupt request flop
      logic irq;                     // registered request level
   } uhb_dev_st_t;

   uhb_dev_st_t ff, nxt_ff;          // state and next state
   logic [7:0] rsel;                 // addressed register content
   logic wr_fall;                    // agreed write strobe has just fallen
   logic [SRC_W-1:0] clr;            // status clear request
   logic mode_at_rst;                // clock mode seen through the rts synchroniser

   // read mux
   always_comb begin
      rsel = RST_BYTE;
      // decode uses the raw address: it is settled long before
      // the agreed read level lets the byte onto the bus
      // address decode
      unique case (bus.reg_addr)
         REG_SCRATCH: rsel = ff.scratch;
         REG_SRC_STAT: rsel = 8'(ff.stat);
         REG_SRC_MASK: rsel = 8'(ff.smask);
         REG_GLB_MASK: rsel = 8'(ff.glb_en);
         REG_GP_OUT: rsel = 8'(ff.gp);
         REG_CLK_MODE: rsel = 8'(ff.mode);
         default: rsel = RST_BYTE;   // unused addresses read zero
      endcase
   end

   // next state
   always_comb begin
      nxt_ff = ff;
      // three-stage sampling of host strobes, any phase
      nxt_ff.cs_s = {ff.cs_s[1:0], bus.cs_n};
      nxt_ff.rd_s = {ff.rd_s[1:0], bus.rd_n};
      nxt_ff.wr_s = {ff.wr_s[1:0], bus.wr_n};
      nxt_ff.rts_s = {ff.rts_s[1:0], rts_pin_i};

      // a level counts only once the second and third flops agree
      if (ff.cs_s[2] == ff.cs_s[1]) begin
         nxt_ff.cs_q = ff.cs_s[2];
      end
      // read strobe agreement
      if (ff.rd_s[2] == ff.rd_s[1]) begin
         nxt_ff.rd_q = ff.rd_s[2];
      end
      // write strobe agreement
      if (ff.wr_s[2] == ff.wr_s[1]) begin
         nxt_ff.wr_q = ff.wr_s[2];
      end
      // clock mode follows the agreed rts level; taken only under reset
      mode_at_rst = ff.mode;
      if (ff.rts_s[2] == ff.rts_s[1]) begin
         mode_at_rst = ff.rts_s[2];
      end

      // a write is taken when the agreed strobe falls, while the host still
      // drives the byte; at release it would be too late, the host lets go of
      // the bus one clock after its strobe, before the release is agreed
      wr_fall = ff.wr_q == 1'b1 && nxt_ff.wr_q == 1'b0 && ff.cs_q == 1'b0;
      clr = '0;

      // read places addressed byte; only under agreed select
      // the raw select is not read here: only synchronised select and strobe levels reach a flop
      nxt_ff.drv = ~nxt_ff.rd_q & ~nxt_ff.cs_q;
      // refresh the byte while the read lasts
      if (nxt_ff.drv) begin
         nxt_ff.rdat = rsel;
      end

      // capture on write; deselected means no change
      if (wr_fall) begin
         unique case (bus.reg_addr)
            REG_SCRATCH: nxt_ff.scratch = bus.host_bus_byte;
            REG_SRC_STAT: clr = bus.host_bus_byte[SRC_W-1:0];
            REG_SRC_MASK: nxt_ff.smask = bus.host_bus_byte[SRC_W-1:0];
            REG_GLB_MASK: nxt_ff.glb_en = bus.host_bus_byte[GLB_EN_BIT];
            REG_GP_OUT: nxt_ff.gp = bus.host_bus_byte[GP_OUT_BIT];
            default: ;               // read-only or unused: ignored
         endcase
      end

      // sticky sources; a new event wins over a clear
      nxt_ff.stat = (ff.stat & ~clr) | src_evt_i;
      nxt_ff.irq = ff.glb_en & |(ff.stat & ff.smask);

      // mode stays as latched under reset; no write reaches it
      // rst_seen only times the rts pin turnaround after release
      if (!ff.rst_seen) begin
         nxt_ff.rst_seen = 1'b1;
      end
   end

   // state register; reset is synchronous, so the rts samples keep
   // shifting under reset and the mode is known when reset lets go
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ff <= '{
            cs_s: 3'h7,                    // select and strobes read as idle
            rd_s: 3'h7,
            wr_s: 3'h7,
            rts_s: nxt_ff.rts_s,           // pin sampled during reset
            rd_q: 1'b1,
            wr_q: 1'b1,
            cs_q: 1'b1,
            rdat: RST_BYTE,
            drv: 1'b0,                     // bus undriven
            scratch: RST_BYTE,
            stat: '0,
            smask: '0,
            glb_en: 1'b0,
            gp: 1'b0,
            mode: mode_at_rst,             // mode is only taken here
            rst_seen: 1'b0,
            irq: 1'b0
         };
      end else begin
         ff <= nxt_ff;
      end
   end

   // drive only while a read is in progress
   assign bus.host_bus_byte_d_o = ff.rdat;
   // raw select gates the enable, so a deselected port lets go at once
   // one of the few combinational uses of a raw pin, and it only masks an output
   assign bus.host_bus_byte_d_oe_n = ~(ff.drv & ~bus.cs_n);
   // limitation: after a read the agreed read level needs a few clocks to
   // return high, so the host must leave select high for a few clocks between
   // accesses or the old byte reappears on the bus

   assign bus.irq = ff.irq;

   // rts is an input during reset and until the first cycle after
   assign rts_pin_oe_n_o = rst_i | ~ff.rst_seen;
   // once released the pin shows the level the core asks for
   assign rts_pin_o = rts_req_i;

   // second pin is oscillator output in crystal mode, gp output otherwise
   assign gp_out_or_xtal_out_o = (ff.mode == UHB_CLK_XTAL) ? ~osc_fb_i : ff.gp;
   // the second pin is an output in both modes
   assign gp_out_or_xtal_out_oe_n_o = 1'b0;
   // mirrors for the core
   assign gp_out_o = 8'(ff.gp);
   assign clk_mode_o = ff.mode;
endmodule // uhb_dev

// file: core/uhb_pkg.sv
// uhb_pkg: shared constants and types for the host byte port and clock pins
// assumes: both ends of the host port compile against this package
package uhb_pkg;
   localparam int ADDR_W = 3;              // register address width
   localparam int DATA_W = 8;              // data bus width
   localparam int NUM_REGS = 8;            // registers reachable by the address
   localparam int SRC_W = 4;               // interrupt sources modelled
   // register indices inside the device end
   localparam logic [2:0] REG_SCRATCH = 3'h0;  // plain read/write byte
   localparam logic [2:0] REG_SRC_STAT = 3'h1; // source status, write 1 to clear
   localparam logic [2:0] REG_SRC_MASK = 3'h2; // per-source mask (second level)
   localparam logic [2:0] REG_GLB_MASK = 3'h3; // block mask (first level), bit 0
   localparam logic [2:0] REG_GP_OUT = 3'h4;   // general output two, bit 0
   localparam logic [2:0] REG_CLK_MODE = 3'h5; // clock mode, read only, bit 0
   localparam logic [7:0] RST_BYTE = 8'h00;    // wake-up value of every register but the clock mode
   localparam int GP_OUT_BIT = 0;              // field position of gp output
   localparam int CLK_MODE_BIT = 0;            // field position of clock mode
   localparam int GLB_EN_BIT = 0;              // field position of block enable
   // clock mode latched at reset
   typedef enum logic {UHB_CLK_EXT, UHB_CLK_XTAL} uhb_clk_mode_t;
   // host sequencer states
   typedef enum logic [1:0] {UHB_IDLE, UHB_SETUP, UHB_STROBE, UHB_DONE} uhb_hst_state_t;
   localparam int STROBE_CYC = 2;              // not used; the host strobe stays low for HOLD_CYC plus one cycles
endpackage : uhb_pkg

// file: core/uhb_if.sv
// uhb_if: host byte port wires between the host end and the device end
// assumes: a bench resolves the shared data byte from the two enables
`timescale 1ns/1ps
interface uhb_if;
   logic cs_n;                        // chip select, active low
   logic rd_n;                        // read strobe, active low
   logic wr_n;                        // write strobe, active low
   logic [2:0] reg_addr;              // register address
   logic [7:0] host_bus_byte_h_o;     // host drive value
   logic host_bus_byte_h_oe_n;        // host drive enable, low drives
   logic [7:0] host_bus_byte_d_o;     // device drive value
   logic host_bus_byte_d_oe_n;        // device drive enable, low drives
   logic [7:0] host_bus_byte;         // resolved bus level, set by bench
   logic irq;                         // interrupt request, active high
   modport dev (input cs_n, input rd_n, input wr_n, input reg_addr, input host_bus_byte,
      output host_bus_byte_d_o, output host_bus_byte_d_oe_n, output irq);
   modport host (output cs_n, output rd_n, output wr_n, output reg_addr, input host_bus_byte,
      output host_bus_byte_h_o, output host_bus_byte_h_oe_n, input irq);
endinterface : uhb_if

// file: core/uhb_host.sv
// uhb_host: host end, runs one register read or write per request
// assumes: device end samples strobes through its own synchronisers
`timescale 1ns/1ps
module uhb_host #(
   parameter int HOLD_CYC = 6                       // strobe low length is this plus one, cycles
) (
   input wire logic clk_sys_i,                      // host clock
   input wire logic rst_i,                          // synchronous reset, high
   uhb_if.host bus,                                 // device side
   input wire logic req_i,                          // start an access
   input wire logic we_i,                           // 1 write, 0 read
   input wire logic [uhb_pkg::ADDR_W-1:0] addr_i,   // register address
   input wire logic [uhb_pkg::DATA_W-1:0] wdata_i,  // write byte
   output logic ready_o,                            // idle, request accepted
   output logic done_o,                             // access finished, pulse
   output logic [uhb_pkg::DATA_W-1:0] rdata_o,      // read byte
   output logic irq_o                               // irq seen from device
);
   import uhb_pkg::*;

   // host state in one struct
   typedef struct packed {
      uhb_hst_state_t st;
      logic we;
      logic [2:0] addr;
      logic [7:0] wd;
      logic [7:0] rd;
      logic [7:0] cnt;
      logic done;
   } uhb_hst_st_t;

   uhb_hst_st_t ff, nxt_ff;

   // sequencer: setup, strobe held, release
   always_comb begin
      nxt_ff = ff;
      nxt_ff.done = 1'b0;
      unique case (ff.st)
         UHB_IDLE: begin
            if (req_i) begin
               nxt_ff.we = we_i;
               nxt_ff.addr = addr_i;
               nxt_ff.wd = wdata_i;
               nxt_ff.cnt = 8'(HOLD_CYC);
               nxt_ff.st = UHB_SETUP;
            end
         end
         UHB_SETUP: nxt_ff.st = UHB_STROBE;
         UHB_STROBE: begin
            // long hold covers the device's synchroniser delay
            if (ff.cnt == 8'h00) begin
               nxt_ff.rd = bus.host_bus_byte;
               nxt_ff.st = UHB_DONE;
            end else begin
               nxt_ff.cnt = ff.cnt - 8'h01;
            end
         end
         UHB_DONE: begin
            nxt_ff.done = 1'b1;
            nxt_ff.st = UHB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ff <= '{st: UHB_IDLE, we: 1'b0, addr: '0, wd: RST_BYTE, rd: RST_BYTE, cnt: '0, done: 1'b0};
      end else begin
         ff <= nxt_ff;
      end
   end

   // select low across setup, strobe and release
   assign bus.cs_n = (ff.st == UHB_IDLE);
   // address stable for the whole access
   assign bus.reg_addr = ff.addr;
   // one strobe low during the strobe phase
   assign bus.rd_n = ~(ff.st == UHB_STROBE && !ff.we);
   assign bus.wr_n = ~(ff.st == UHB_STROBE && ff.we);
   // host drives the byte through writes, including release
   assign bus.host_bus_byte_h_o = ff.wd;
   assign bus.host_bus_byte_h_oe_n = ~(ff.we && ff.st != UHB_IDLE);
   assign ready_o = (ff.st == UHB_IDLE);
   assign done_o = ff.done;
   assign rdata_o = ff.rd;
   assign irq_o = bus.irq;
endmodule // uhb_host

// file: testbench/uhb_monitor.sv
// uhb_monitor: timing checks on the host byte port wires
// assumes: sits beside the interface; host strobe low length is 7 cycles
`timescale 1ns/1ps
module uhb_monitor (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] host_bus_byte_h_o,
   input wire logic host_bus_byte_h_oe_n,
   input wire logic host_bus_byte_d_oe_n
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   a_select_gates_strobe: assert property ((!rd_n || !wr_n) |-> !cs_n)
      else $error("strobe seen without chip select");
   a_addr_held_select: assert property (!cs_n && $past(!cs_n) |-> $stable(reg_addr))
      else $error("address moved during an access");
   a_device_quiet_idle: assert property (cs_n && $past(cs_n) |-> host_bus_byte_d_oe_n)
      else $error("device drives bus while deselected");
   a_read_only_drive: assert property (rd_n [*6] |-> host_bus_byte_d_oe_n)
      else $error("device drives bus outside a read");
   a_bus_no_fight: assert property (!(!host_bus_byte_d_oe_n && !host_bus_byte_h_oe_n))
      else $error("both ends drive the data bus");
   a_write_data_held: assert property (!wr_n |-> !host_bus_byte_h_oe_n && $stable(host_bus_byte_h_o))
      else $error("write byte not held under strobe");
   a_write_strobe_len: assert property ($fell(wr_n) |-> !wr_n [*7] ##1 wr_n)
      else $error("write strobe length wrong");
   a_read_strobe_len: assert property ($fell(rd_n) |-> (!rd_n && wr_n) [*7] ##1 rd_n)
      else $error("read strobe length wrong");
endmodule // uhb_monitor

// file: testbench/uart_host_bus_and_clock_pins_test.sv
// host end and device end joined by the interface, checked from the user side
// assumes: package and interface compiled first; HOLD_CYC kept at 6
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", n, e, g); end end
module uart_host_bus_and_clock_pins_test;
   import uhb_pkg::*;
   typedef struct packed {logic we; logic [2:0] a; logic [7:0] d; logic [7:0] e;} uhb_row_t;
   // table rows: write flag, address, write byte, expected read byte
   localparam uhb_row_t ROWS [10] = '{'{1'b1, 3'h0, 8'ha5, 8'h00}, '{1'b0, 3'h0, 8'h00, 8'ha5},
      '{1'b1, 3'h0, 8'h5a, 8'h00}, '{1'b0, 3'h0, 8'h00, 8'h5a}, '{1'b0, 3'h2, 8'h00, 8'h00},
      '{1'b1, 3'h6, 8'hff, 8'h00}, '{1'b0, 3'h6, 8'h00, 8'h00}, '{1'b0, 3'h7, 8'h00, 8'h00},
      '{1'b1, 3'h5, 8'h01, 8'h00}, '{1'b1, 3'h4, 8'h01, 8'h00}};
   logic clk_sys_i = 1'b0, rst_i = 1'b1, req = 1'b0, we = 1'b0, rts_pin = 1'b0, osc_fb = 1'b0;
   logic [2:0] addr = 3'h0; // access address
   logic [7:0] wdata = 8'h00; // write byte
   logic [3:0] src_evt = 4'h0; // interrupt event pulses
   logic ready, done, irq_o, rts_oe_n, rts_o, gpx, gpx_oe_n, clk_mode;
   logic [7:0] rdata, gp_out;
   int failures = 0, num_checks = 0;
   uhb_if bif();
   // the bench resolves the shared byte; undriven shows as high impedance
   assign bif.host_bus_byte = !bif.host_bus_byte_d_oe_n ? bif.host_bus_byte_d_o :
      !bif.host_bus_byte_h_oe_n ? bif.host_bus_byte_h_o : 8'hzz;
   uhb_host #(.HOLD_CYC(6)) uhb_host_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus(bif.host), .req_i(req),
      .we_i(we), .addr_i(addr), .wdata_i(wdata), .ready_o(ready), .done_o(done), .rdata_o(rdata), .irq_o(irq_o));
   uhb_dev uhb_dev_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus(bif.dev), .src_evt_i(src_evt),
      .rts_pin_i(rts_pin), .rts_pin_oe_n_o(rts_oe_n), .rts_pin_o(rts_o), .rts_req_i(1'b1),
      .gp_out_or_xtal_out_o(gpx), .gp_out_or_xtal_out_oe_n_o(gpx_oe_n), .osc_fb_i(osc_fb),
      .gp_out_o(gp_out), .clk_mode_o(clk_mode));
   uhb_monitor uhb_monitor_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n(bif.cs_n), .rd_n(bif.rd_n),
      .wr_n(bif.wr_n), .reg_addr(bif.reg_addr), .host_bus_byte_h_o(bif.host_bus_byte_h_o),
      .host_bus_byte_h_oe_n(bif.host_bus_byte_h_oe_n), .host_bus_byte_d_oe_n(bif.host_bus_byte_d_oe_n));
   // 100 MHz external system clock at logic levels
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // verdict in one place
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // one access; waits on done under a bound, then lets the device settle
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      int n;
      @(negedge clk_sys_i);
      req = 1'b1; we = w; addr = a; wdata = d;
      @(negedge clk_sys_i);
      req = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 30) begin
         @(negedge clk_sys_i);
         n++;
      end
      `CHK("done", 1'b1, done)
      repeat (5) @(negedge clk_sys_i);
   endtask
   // reset held 20 cycles, rts level sampled at release
   task automatic rst_dev(input logic rts);
      @(negedge clk_sys_i);
      rst_i = 1'b1; rts_pin = rts;
      repeat (20) @(negedge clk_sys_i);
      `CHK("rts in reset", 1'b1, rts_oe_n)
      rst_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
   endtask
   // one-cycle event on source 0, then time for the irq register
   task automatic pulse();
      @(negedge clk_sys_i);
      src_evt = 4'h1;
      @(negedge clk_sys_i);
      src_evt = 4'h0;
      repeat (4) @(negedge clk_sys_i);
   endtask
   // watchdog: the run needs about 400 cycles
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      failures++;
      complete_run();
   end
   initial begin
      rst_dev(1'b0);
      `CHK("clk_mode", 1'b0, clk_mode)
      `CHK("irq", 1'b0, irq_o)
      `CHK("rts_oe_n", 1'b0, rts_oe_n)
      `CHK("rts out", 1'b1, rts_o)
      `CHK("ready", 1'b1, ready)
      `CHK("bus idle", 8'hzz, bif.host_bus_byte)
      $display("test wake-up done");
      foreach (ROWS[i]) begin
         acc(ROWS[i].we, ROWS[i].a, ROWS[i].d);
         if (!ROWS[i].we) `CHK("rdata", ROWS[i].e, rdata)
      end
      acc(1'b0, 3'h5, 8'h00);
      `CHK("mode read", 8'h00, rdata)
      `CHK("gp pin", 1'b1, gpx)
      `CHK("gp mirror", 8'h01, gp_out)
      `CHK("gp pin drives", 1'b0, gpx_oe_n)
      $display("test table done");
      // mask at both levels, then clear by writing one
      acc(1'b1, 3'h2, 8'h01);
      acc(1'b1, 3'h3, 8'h00);
      pulse();
      `CHK("irq block off", 1'b0, irq_o)
      acc(1'b0, 3'h1, 8'h00);
      `CHK("status", 8'h01, rdata)
      acc(1'b1, 3'h3, 8'h01);
      `CHK("irq on", 1'b1, irq_o)
      acc(1'b1, 3'h2, 8'h00);
      `CHK("irq source off", 1'b0, irq_o)
      acc(1'b1, 3'h1, 8'h01);
      acc(1'b1, 3'h2, 8'h01);
      `CHK("irq cleared", 1'b0, irq_o)
      $display("test irq done");
      // crystal mode latched from the rts level at reset
      rst_dev(1'b1);
      acc(1'b0, 3'h0, 8'h00);
      `CHK("scratch reset", 8'h00, rdata)
      `CHK("clk_mode", 1'b1, clk_mode)
      `CHK("osc out", 1'b1, gpx)
      acc(1'b1, 3'h4, 8'h01);
      osc_fb = 1'b1;
      #1 `CHK("osc not gp", 1'b0, gpx)
      acc(1'b1, 3'h5, 8'h00);
      acc(1'b0, 3'h5, 8'h00);
      `CHK("mode kept", 8'h01, rdata)
      $display("test crystal done");
      complete_run();
   end
endmodule // uart_host_bus_and_clock_pins_test
